// [logic/cilr_cfg.svh]
// constants for the camera io line router: map, fields, bit places, timing
`ifndef CILR_CFG_SVH
`define CILR_CFG_SVH

`define CILR_AW 8
`define CILR_DW 32
`define CILR_TW 16
`define CILR_CW 17
`define CILR_LSV_W 14
`define CILR_NIN 4
`define CILR_NPU 4
`define CILR_NCH 3
`define CILR_SRC_N 32

`define CILR_A_LSV 8'h00
`define CILR_A_ROUTE1 8'h04
`define CILR_A_ROUTE4 8'h08
`define CILR_A_SWOUT 8'h0C
`define CILR_A_EXPCTL 8'h10
`define CILR_A_EXP_R 8'h14
`define CILR_A_EXP_G 8'h18
`define CILR_A_EXP_B 8'h1C
`define CILR_A_PU 8'h40
`define CILR_PU_MASK 8'hC0
`define CILR_PU_UNIT 5:4
`define CILR_PU_WORD 3:2
`define CILR_W_PERIOD 2'h0
`define CILR_W_RISE 2'h1
`define CILR_W_FALL 2'h2
`define CILR_W_CLEAR 2'h3

`define CILR_F_ROUTE 4:0
`define CILR_F_INV 8
`define CILR_F_PICK 1:0
`define CILR_F_LEVEL 4
`define CILR_F_SWRD 3:0
`define CILR_F_SCHEME 0
`define CILR_F_EXPCH 5:4
`define CILR_F_CAPST 8
`define CILR_F_EXPST 9
`define CILR_F_TIME 15:0
`define CILR_F_CLRSRC 4:0
`define CILR_F_CLRMODE 8

`define CILR_B_OUT1 0
`define CILR_B_IN1 3
`define CILR_B_OPTO 4
`define CILR_B_COAX 6
`define CILR_B_OUT4 11
`define CILR_B_IN4 13

`define CILR_CH_R 0
`define CILR_CH_G 1
`define CILR_CH_B 2

`define CILR_CLK_NS 10
`define CILR_EXP_OFS_NS 3110
`define CILR_EXP_OFS_CYC ((`CILR_EXP_OFS_NS + `CILR_CLK_NS - 1) / `CILR_CLK_NS)

`endif

// [logic/cilr_pkg.sv]
// types shared by the camera io line router modules
`default_nettype none
`include "cilr_cfg.svh"

package cilr_pkg;

   typedef enum logic [4:0] {
      RT_OFF, RT_CAPTURE, RT_EXPOSURE, RT_LINE_VALID,
      RT_PULSE0, RT_PULSE1, RT_PULSE2, RT_PULSE3,
      RT_SW0, RT_SW1, RT_SW2, RT_SW3,
      RT_IN0, RT_IN1, RT_IN2, RT_IN3,
      RT_LOGIC0, RT_LOGIC1, RT_LOGIC2, RT_LOGIC3,
      RT_ENC_PULSE, RT_ENC_SENSE
   } cilr_route_e;

   typedef enum logic [4:0] {
      CL_NONE, CL_EXPOSURE, CL_LINE_VALID,
      CL_PULSE0, CL_PULSE1, CL_PULSE2, CL_PULSE3,
      CL_SW0, CL_SW1, CL_SW2, CL_SW3,
      CL_IN0, CL_IN1, CL_IN2, CL_IN3,
      CL_LOGIC0, CL_LOGIC1, CL_LOGIC2, CL_LOGIC3,
      CL_ENC_PULSE
   } cilr_clear_e;

   typedef enum logic [1:0] {EC_COMMON, EC_RED, EC_GREEN, EC_BLUE} cilr_expch_e;
   typedef enum logic {TS_COMMON, TS_INDIVIDUAL} cilr_scheme_e;

   typedef struct packed {
      logic [`CILR_TW-1:0] cnt;
      logic clr_d;
      logic pend;
      logic out;
   } cilr_pu_s;

endpackage : cilr_pkg
`default_nettype wire

// [logic/cilr_pulse_unit.sv]
// one pulse unit: period counter, rise/fall window, selectable clear
`timescale 1ns/1ps
`default_nettype none
`include "cilr_cfg.svh"

module cilr_pulse_unit (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // settings
   input wire logic [`CILR_TW-1:0] period,
   input wire logic [`CILR_TW-1:0] rise,
   input wire logic [`CILR_TW-1:0] fall,
   input wire logic clr_async,
   // clear source level and pulse output
   input wire logic clr_level,
   output logic pulse_out
);

   cilr_pkg::cilr_pu_s s_reg;
   cilr_pkg::cilr_pu_s s_next;
   logic fire;
   logic restart;

   always_comb begin
      s_next = s_reg;
      s_next.clr_d = clr_level;
      fire = clr_level & ~s_reg.clr_d;
      // sync clear waits for a running pulse to finish so it is never cut
      if (clr_async) begin
         restart = fire;
      end else begin
         restart = (fire | s_reg.pend) & ~s_reg.out;
      end
      if (fire & ~clr_async) begin
         s_next.pend = 1'h1;
      end
      if (restart) begin
         s_next.cnt = '0;
         s_next.pend = 1'h0;
      end else if (period == '0) begin
         s_next.cnt = '0;
      end else if (s_reg.cnt >= period - `CILR_TW'(1)) begin
         s_next.cnt = '0;
      end else begin
         s_next.cnt = s_reg.cnt + `CILR_TW'(1);
      end
      s_next.out = (s_next.cnt >= rise) && (s_next.cnt < fall);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign pulse_out = s_reg.out;

endmodule : cilr_pulse_unit
`default_nettype wire

// [logic/cilr_router.sv]
// camera io line router: line status, output routing, exposure, pulse units
// Contract
// - outputs one and four at bits 0, 11
// - inputs at bits 3, 4, 6, 13
// - low reads false, high reads true
// - output inversion switchable, input inversion off
// - capture window from begin to end command
// - exposure window includes sensor exposure offset
// - line readout valid routable while line reads
// - four software outputs set by pick, level
// - routes offer pulses, logic, inputs, encoder
// - common choice follows longest colour channel
// - pulse clear chosen from listed sources
// - pulse unit never clears itself
// - longest channel starts first, all end together
`timescale 1ns/1ps
`default_nettype none
`include "cilr_cfg.svh"

module cilr_router (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // register port
   input wire logic [`CILR_AW-1:0] reg_addr,
   input wire logic [`CILR_DW-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [`CILR_DW-1:0] reg_rdata,
   // input pins, asynchronous
   input wire logic ttl_input_one,
   input wire logic opto_input_one,
   input wire logic coax_link_input,
   input wire logic ttl_input_four,
   // internal sources, same clock
   input wire logic capture_begin_cmd,
   input wire logic capture_end_cmd,
   input wire logic exposure_trigger,
   input wire logic sensor_line_valid,
   input wire logic [`CILR_NPU-1:0] logic_block_out,
   input wire logic encoder_pulse,
   input wire logic encoder_rotation_sense,
   // output pins and status
   output logic ttl_output_one,
   output logic ttl_output_four,
   output logic capture_window,
   output logic exposure_window,
   output logic [`CILR_LSV_W-1:0] line_state_vector
);

   typedef struct packed {
      logic [`CILR_NIN-1:0] sync1;
      logic [`CILR_NIN-1:0] sync2;
      logic [`CILR_NIN-1:0] sync3;
      logic [`CILR_NIN-1:0] filt;
      cilr_pkg::cilr_route_e route1;
      cilr_pkg::cilr_route_e route4;
      logic inv1;
      logic inv4;
      logic [`CILR_NPU-1:0] sw;
      cilr_pkg::cilr_scheme_e scheme;
      cilr_pkg::cilr_expch_e ex_pick;
      logic [`CILR_NCH-1:0][`CILR_TW-1:0] exp_t;
      logic [`CILR_NCH-1:0][`CILR_TW-1:0] lat;
      logic run;
      logic [`CILR_CW-1:0] cnt;
      logic [`CILR_NCH-1:0] exp_ch;
      logic [`CILR_NPU-1:0][`CILR_TW-1:0] pu_period;
      logic [`CILR_NPU-1:0][`CILR_TW-1:0] pu_rise;
      logic [`CILR_NPU-1:0][`CILR_TW-1:0] pu_fall;
      logic [`CILR_NPU-1:0][4:0] pu_clr;
      logic [`CILR_NPU-1:0] pu_mode;
      logic capture;
      logic out1;
      logic out4;
      logic expw;
      logic [`CILR_LSV_W-1:0] lsv;
      logic [`CILR_DW-1:0] rdata;
   } cilr_state_s;

   cilr_state_s s_reg;
   cilr_state_s s_next;
   logic [`CILR_SRC_N-1:0] src_vec;
   logic [`CILR_SRC_N-1:0] clr_vec;
   logic [`CILR_NPU-1:0] pu_out;
   logic [`CILR_NCH-1:0][`CILR_TW-1:0] eff_t;
   logic [1:0] mx_cur;
   logic [1:0] mx_nxt;
   logic [`CILR_CW-1:0] end_cnt;
   logic pu_hit;
   logic [1:0] pu_idx;
   logic [4:0] self_code;

   // ties go to the lowest channel; equal times start together anyway
   function automatic logic [1:0] longest(
      input logic [`CILR_NCH-1:0][`CILR_TW-1:0] t);
      logic [1:0] k;
      k = 2'h0;
      if (t[`CILR_CH_G] > t[k]) begin
         k = 2'h1;
      end
      if (t[`CILR_CH_B] > t[k]) begin
         k = 2'h2;
      end
      return k;
   endfunction : longest

   assign pu_hit = (reg_addr & `CILR_PU_MASK) == `CILR_A_PU;
   assign pu_idx = reg_addr[`CILR_PU_UNIT];
   assign self_code = 5'(cilr_pkg::CL_PULSE0) + {3'h0, pu_idx};
   assign mx_cur = longest(s_reg.lat);
   assign end_cnt = `CILR_CW'(s_reg.lat[mx_cur])
      + `CILR_CW'(`CILR_EXP_OFS_CYC) - `CILR_CW'(1);

   // source selectors; codes past the last source read as low
   always_comb begin
      src_vec = '0;
      clr_vec = '0;
      src_vec[cilr_pkg::RT_CAPTURE] = s_reg.capture;
      src_vec[cilr_pkg::RT_EXPOSURE] = s_reg.expw;
      src_vec[cilr_pkg::RT_LINE_VALID] = sensor_line_valid;
      src_vec[cilr_pkg::RT_ENC_PULSE] = encoder_pulse;
      src_vec[cilr_pkg::RT_ENC_SENSE] = encoder_rotation_sense;
      clr_vec[cilr_pkg::CL_EXPOSURE] = s_reg.expw;
      clr_vec[cilr_pkg::CL_LINE_VALID] = sensor_line_valid;
      clr_vec[cilr_pkg::CL_ENC_PULSE] = encoder_pulse;
      for (int i = 0; i < `CILR_NPU; i++) begin
         src_vec[cilr_pkg::RT_PULSE0 + i] = pu_out[i];
         src_vec[cilr_pkg::RT_SW0 + i] = s_reg.sw[i];
         src_vec[cilr_pkg::RT_IN0 + i] = s_reg.filt[i];
         src_vec[cilr_pkg::RT_LOGIC0 + i] = logic_block_out[i];
         clr_vec[cilr_pkg::CL_PULSE0 + i] = pu_out[i];
         clr_vec[cilr_pkg::CL_SW0 + i] = s_reg.sw[i];
         clr_vec[cilr_pkg::CL_IN0 + i] = s_reg.filt[i];
         clr_vec[cilr_pkg::CL_LOGIC0 + i] = logic_block_out[i];
      end
   end

   generate
      for (genvar u = 0; u < `CILR_NPU; u++) begin : g_pu
         cilr_pulse_unit u_pu (
            .clk(clk),
            .rst_n(rst_n),
            .period(s_reg.pu_period[u]),
            .rise(s_reg.pu_rise[u]),
            .fall(s_reg.pu_fall[u]),
            .clr_async(s_reg.pu_mode[u]),
            .clr_level(clr_vec[s_reg.pu_clr[u]]),
            .pulse_out(pu_out[u])
         );
      end
   endgenerate

   always_comb begin
      s_next = s_reg;
      mx_nxt = 2'h0;
      // inputs: three stages, a change counts once stages two and three agree
      s_next.sync1 = {ttl_input_four, coax_link_input,
         opto_input_one, ttl_input_one};
      s_next.sync2 = s_reg.sync1;
      s_next.sync3 = s_reg.sync2;
      for (int i = 0; i < `CILR_NIN; i++) begin
         if (s_reg.sync2[i] == s_reg.sync3[i]) begin
            s_next.filt[i] = s_reg.sync3[i];
         end
      end
      // end command wins over a begin in the same cycle
      if (capture_end_cmd) begin
         s_next.capture = 1'h0;
      end else if (capture_begin_cmd) begin
         s_next.capture = 1'h1;
      end
      if (reg_wr) begin
         case (reg_addr)
            `CILR_A_ROUTE1: begin
               s_next.route1 =
                  cilr_pkg::cilr_route_e'(reg_wdata[`CILR_F_ROUTE]);
               s_next.inv1 = reg_wdata[`CILR_F_INV];
            end
            `CILR_A_ROUTE4: begin
               s_next.route4 =
                  cilr_pkg::cilr_route_e'(reg_wdata[`CILR_F_ROUTE]);
               s_next.inv4 = reg_wdata[`CILR_F_INV];
            end
            `CILR_A_SWOUT: begin
               s_next.sw[reg_wdata[`CILR_F_PICK]] =
                  reg_wdata[`CILR_F_LEVEL];
            end
            `CILR_A_EXPCTL: begin
               s_next.scheme =
                  cilr_pkg::cilr_scheme_e'(reg_wdata[`CILR_F_SCHEME]);
               s_next.ex_pick =
                  cilr_pkg::cilr_expch_e'(reg_wdata[`CILR_F_EXPCH]);
            end
            `CILR_A_EXP_R: begin
               s_next.exp_t[`CILR_CH_R] = reg_wdata[`CILR_F_TIME];
            end
            `CILR_A_EXP_G: begin
               s_next.exp_t[`CILR_CH_G] = reg_wdata[`CILR_F_TIME];
            end
            `CILR_A_EXP_B: begin
               s_next.exp_t[`CILR_CH_B] = reg_wdata[`CILR_F_TIME];
            end
            default: begin
               if (pu_hit) begin
                  case (reg_addr[`CILR_PU_WORD])
                     `CILR_W_PERIOD: begin
                        s_next.pu_period[pu_idx] = reg_wdata[`CILR_F_TIME];
                     end
                     `CILR_W_RISE: begin
                        s_next.pu_rise[pu_idx] = reg_wdata[`CILR_F_TIME];
                     end
                     `CILR_W_FALL: begin
                        s_next.pu_fall[pu_idx] = reg_wdata[`CILR_F_TIME];
                     end
                     `CILR_W_CLEAR: begin
                        // a self clear would lock the unit; the whole write drops
                        if (reg_wdata[`CILR_F_CLRSRC] != self_code) begin
                           s_next.pu_clr[pu_idx] = reg_wdata[`CILR_F_CLRSRC];
                           s_next.pu_mode[pu_idx] = reg_wdata[`CILR_F_CLRMODE];
                        end
                     end
                  endcase
               end
            end
         endcase
      end
      // exposure engine: one counter, channel starts staggered by time
      if (s_reg.scheme == cilr_pkg::TS_INDIVIDUAL) begin
         eff_t = s_reg.exp_t;
      end else begin
         eff_t = {`CILR_NCH{s_reg.exp_t[`CILR_CH_R]}};
      end
      if (!s_reg.run) begin
         // times are latched so a write during exposure cannot tear it
         if (exposure_trigger) begin
            s_next.run = 1'h1;
            s_next.cnt = '0;
            s_next.lat = eff_t;
         end
      end else if (s_reg.cnt == end_cnt) begin
         s_next.run = 1'h0;
      end else begin
         s_next.cnt = s_reg.cnt + `CILR_CW'(1);
      end
      mx_nxt = longest(s_next.lat);
      for (int c = 0; c < `CILR_NCH; c++) begin
         s_next.exp_ch[c] = s_next.run && (s_next.cnt >=
            `CILR_CW'(s_next.lat[mx_nxt] - s_next.lat[c]));
      end
      case (s_reg.ex_pick)
         cilr_pkg::EC_COMMON: s_next.expw = s_next.exp_ch[mx_nxt];
         cilr_pkg::EC_RED: s_next.expw = s_next.exp_ch[`CILR_CH_R];
         cilr_pkg::EC_GREEN: s_next.expw = s_next.exp_ch[`CILR_CH_G];
         cilr_pkg::EC_BLUE: s_next.expw = s_next.exp_ch[`CILR_CH_B];
      endcase
      // outputs; inputs carry no inverter at all
      s_next.out1 = src_vec[s_reg.route1] ^ s_reg.inv1;
      s_next.out4 = src_vec[s_reg.route4] ^ s_reg.inv4;
      s_next.lsv = '0;
      s_next.lsv[`CILR_B_OUT1] = s_reg.out1;
      s_next.lsv[`CILR_B_OUT4] = s_reg.out4;
      s_next.lsv[`CILR_B_IN1] = s_reg.filt[0];
      s_next.lsv[`CILR_B_OPTO] = s_reg.filt[1];
      s_next.lsv[`CILR_B_COAX] = s_reg.filt[2];
      s_next.lsv[`CILR_B_IN4] = s_reg.filt[3];
      // read data stand for one cycle only
      s_next.rdata = '0;
      if (reg_rd) begin
         case (reg_addr)
            `CILR_A_LSV: s_next.rdata[`CILR_LSV_W-1:0] = s_reg.lsv;
            `CILR_A_ROUTE1: begin
               s_next.rdata[`CILR_F_ROUTE] = s_reg.route1;
               s_next.rdata[`CILR_F_INV] = s_reg.inv1;
            end
            `CILR_A_ROUTE4: begin
               s_next.rdata[`CILR_F_ROUTE] = s_reg.route4;
               s_next.rdata[`CILR_F_INV] = s_reg.inv4;
            end
            `CILR_A_SWOUT: s_next.rdata[`CILR_F_SWRD] = s_reg.sw;
            `CILR_A_EXPCTL: begin
               s_next.rdata[`CILR_F_SCHEME] = s_reg.scheme;
               s_next.rdata[`CILR_F_EXPCH] = s_reg.ex_pick;
               s_next.rdata[`CILR_F_CAPST] = s_reg.capture;
               s_next.rdata[`CILR_F_EXPST] = s_reg.expw;
            end
            `CILR_A_EXP_R: begin
               s_next.rdata[`CILR_F_TIME] = s_reg.exp_t[`CILR_CH_R];
            end
            `CILR_A_EXP_G: begin
               s_next.rdata[`CILR_F_TIME] = s_reg.exp_t[`CILR_CH_G];
            end
            `CILR_A_EXP_B: begin
               s_next.rdata[`CILR_F_TIME] = s_reg.exp_t[`CILR_CH_B];
            end
            default: begin
               if (pu_hit) begin
                  case (reg_addr[`CILR_PU_WORD])
                     `CILR_W_PERIOD: begin
                        s_next.rdata[`CILR_F_TIME] = s_reg.pu_period[pu_idx];
                     end
                     `CILR_W_RISE: begin
                        s_next.rdata[`CILR_F_TIME] = s_reg.pu_rise[pu_idx];
                     end
                     `CILR_W_FALL: begin
                        s_next.rdata[`CILR_F_TIME] = s_reg.pu_fall[pu_idx];
                     end
                     `CILR_W_CLEAR: begin
                        s_next.rdata[`CILR_F_CLRSRC] = s_reg.pu_clr[pu_idx];
                        s_next.rdata[`CILR_F_CLRMODE] = s_reg.pu_mode[pu_idx];
                     end
                  endcase
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign reg_rdata = s_reg.rdata;
   assign ttl_output_one = s_reg.out1;
   assign ttl_output_four = s_reg.out4;
   assign capture_window = s_reg.capture;
   assign exposure_window = s_reg.expw;
   assign line_state_vector = s_reg.lsv;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   property p_lsv_outputs;
      line_state_vector[`CILR_B_OUT1] == $past(ttl_output_one)
      && line_state_vector[`CILR_B_OUT4] == $past(ttl_output_four);
   endproperty
   a_lsv_outputs: assert property (p_lsv_outputs)
      else $error("output bits of line state vector wrong");

   property p_lsv_inputs;
      line_state_vector[`CILR_B_IN1] == $past(s_reg.filt[0])
      && line_state_vector[`CILR_B_OPTO] == $past(s_reg.filt[1])
      && line_state_vector[`CILR_B_COAX] == $past(s_reg.filt[2])
      && line_state_vector[`CILR_B_IN4] == $past(s_reg.filt[3]);
   endproperty
   a_lsv_inputs: assert property (p_lsv_inputs)
      else $error("input bits of line state vector wrong");

   property p_level_polarity;
      ($stable(ttl_input_one) && $stable(ttl_input_four)) [*8]
      |-> line_state_vector[`CILR_B_IN1] == ttl_input_one
      && line_state_vector[`CILR_B_IN4] == ttl_input_four;
   endproperty
   a_level_polarity: assert property (p_level_polarity)
      else $error("steady input level not shown true high");

   property p_out_invert;
      ttl_output_one == $past(src_vec[s_reg.route1] ^ s_reg.inv1);
   endproperty
   a_out_invert: assert property (p_out_invert)
      else $error("output one not routed source with inversion");

   property p_capture;
      capture_window == (!$past(capture_end_cmd)
         && ($past(capture_begin_cmd) || $past(capture_window)));
   endproperty
   a_capture: assert property (p_capture)
      else $error("capture window not held from begin command");

   property p_exp_length;
      $fell(s_reg.run) |-> $past(s_reg.cnt) + 1
         == $past(s_reg.lat[mx_cur]) + `CILR_EXP_OFS_CYC;
   endproperty
   a_exp_length: assert property (p_exp_length)
      else $error("exposure window length misses offset");

   property p_line_valid;
      s_reg.route1 == cilr_pkg::RT_LINE_VALID && !s_reg.inv1
      |=> ttl_output_one == $past(sensor_line_valid);
   endproperty
   a_line_valid: assert property (p_line_valid)
      else $error("line readout valid not routed");

   property p_sw_write;
      reg_wr && reg_addr == `CILR_A_SWOUT
      |=> s_reg.sw[$past(reg_wdata[`CILR_F_PICK])]
         == $past(reg_wdata[`CILR_F_LEVEL]);
   endproperty
   a_sw_write: assert property (p_sw_write)
      else $error("software output level not stored");

   property p_common_longest;
      $past(s_reg.ex_pick) == cilr_pkg::EC_COMMON
      |-> exposure_window == s_reg.exp_ch[mx_cur];
   endproperty
   a_common_longest: assert property (p_common_longest)
      else $error("common exposure window not longest channel");

   property p_no_self_clear;
      reg_wr && pu_hit && reg_addr[`CILR_PU_WORD] == `CILR_W_CLEAR
      && reg_wdata[`CILR_F_CLRSRC] == self_code
      |=> $stable(s_reg.pu_clr) && $stable(s_reg.pu_mode);
   endproperty
   a_no_self_clear: assert property (p_no_self_clear)
      else $error("pulse unit accepted itself as clear source");

   // every channel is still lit in the last cycle, none after it
   property p_end_together;
      $fell(s_reg.run) |-> $past(s_reg.exp_ch) == '1 && s_reg.exp_ch == '0;
   endproperty
   a_end_together: assert property (p_end_together)
      else $error("colour exposures did not end together");

   property p_all_drop;
      !s_reg.run |-> s_reg.exp_ch == '0;
   endproperty
   a_all_drop: assert property (p_all_drop)
      else $error("colour exposure outlives the window");

   property p_longest_first;
      $rose(s_reg.run) |-> s_reg.exp_ch[mx_cur];
   endproperty
   a_longest_first: assert property (p_longest_first)
      else $error("longest channel did not start first");

endmodule : cilr_router
`default_nettype wire

// [sim/cilr_line_equipment.sv]
// external trigger equipment model: drives the camera input pins
`timescale 1ns/1ps
`default_nettype none

module cilr_line_equipment (
   // requested levels, bit 0 ttl one .. bit 3 ttl four
   input wire logic [3:0] levels,
   // camera input pins
   output logic ttl_input_one,
   output logic opto_input_one,
   output logic coax_link_input,
   output logic ttl_input_four
);
   initial begin
      {ttl_input_four, coax_link_input, opto_input_one, ttl_input_one} = 4'h0;
   end
   // pins move off the camera clock edge so the synchronisers see real skew
   always @(levels) begin
      {ttl_input_four, coax_link_input, opto_input_one, ttl_input_one} <=
         #3 levels;
   end
endmodule : cilr_line_equipment
`default_nettype wire

// [sim/camera_io_line_router_tb.sv]
// self-checking bench for the camera io line router
`timescale 1ns/1ps
`default_nettype none
`include "cilr_cfg.svh"

module camera_io_line_router_tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic cap_go = 1'b0;
   logic cap_stop = 1'b0;
   logic trig = 1'b0;
   logic lv = 1'b0;
   logic [3:0] lb = 4'h0;
   logic enc = 1'b0;
   logic sense = 1'b0;
   logic [3:0] pins = 4'h0;
   logic [31:0] reg_rdata;
   logic in1, opto, coax, in4, out1, out4, capw, expw;
   logic [13:0] lsv;
   logic [31:0] rnd = 32'h2233;
   logic [31:0] exp_q[$];
   logic rd_seen = 1'b0;
   logic [21:0] src;
   int bad_count = 0;
   int checks_done = 0;
   int n;
   int k;

   always #5 clk = ~clk;
   // source value by route code; pulse and software codes are not used here
   assign src = {sense, enc, lb, pins, 8'h0, lv, 3'h0};

   cilr_router cilr_router_i (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .ttl_input_one(in1), .opto_input_one(opto),
      .coax_link_input(coax), .ttl_input_four(in4),
      .capture_begin_cmd(cap_go), .capture_end_cmd(cap_stop),
      .exposure_trigger(trig), .sensor_line_valid(lv), .logic_block_out(lb),
      .encoder_pulse(enc), .encoder_rotation_sense(sense),
      .ttl_output_one(out1), .ttl_output_four(out4), .capture_window(capw),
      .exposure_window(expw), .line_state_vector(lsv));
   cilr_line_equipment cilr_line_equipment_i (.levels(pins),
      .ttl_input_one(in1), .opto_input_one(opto), .coax_link_input(coax),
      .ttl_input_four(in4));

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr
   function automatic logic [31:0] ev(input logic o1, input logic o4);
      return {18'h0, pins[3], 1'b0, o4, 4'h0, pins[2], 1'b0, pins[1],
         pins[0], 2'h0, o1};
   endfunction : ev
   task automatic chk(input logic [31:0] got, input logic [31:0] want);
      checks_done++;
      if (got !== want) begin
         bad_count++;
         $display("BAD t=%0t got %h want %h", $time, got, want);
      end
   endtask : chk
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : end_of_test
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] want);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      exp_q.push_back(want);
      @(posedge clk);
      reg_rd <= 1'b0;
   endtask : rd
   task automatic idle(input int c);
      repeat (c) @(posedge clk);
   endtask : idle
   task automatic expo(input int dly, input int len);
      @(posedge clk) trig <= 1'b1;
      @(posedge clk) trig <= 1'b0;
      n = 0;
      while (expw !== 1'b1 && n < 2000) begin
         @(negedge clk);
         n++;
      end
      chk(n, dly);
      if (n >= 2000) end_of_test();
      n = 0;
      while (expw === 1'b1 && n < 2000) begin
         @(negedge clk);
         n++;
      end
      chk(n, len);
      if (n >= 2000) end_of_test();
   endtask : expo

   // read data stand only in the cycle after the strobe
   always @(posedge clk) rd_seen <= reg_rd;
   always @(negedge clk) begin
      if (rd_seen) chk(reg_rdata, exp_q.pop_front());
   end

   initial begin
      idle(16);
      rst_n <= 1'b1;
      rd(`CILR_A_LSV, 32'h0);
      rd(8'h30, 32'h0);
      wr(`CILR_A_ROUTE4, 32'h100);
      for (int r = 0; r < 3; r++) begin
         rnd = lfsr(rnd);
         {sense, enc, lb, lv, pins} <= rnd[10:0];
         idle(8);
         for (k = 11; k < 22; k++) begin
            n = (k == 11) ? 3 : k;
            wr(`CILR_A_ROUTE1, n);
            idle(4);
            rd(`CILR_A_LSV, ev(src[n], 1'b1));
         end
      end
      for (k = 0; k < 4; k++) begin
         wr(`CILR_A_SWOUT, {27'h0, rnd[k], 2'h0, k[1:0]});
         wr(`CILR_A_ROUTE1, 8 + k);
         idle(4);
         rd(`CILR_A_LSV, ev(rnd[k], 1'b1));
      end
      rd(`CILR_A_SWOUT, {28'h0, rnd[3:0]});
      wr(`CILR_A_ROUTE1, 1);
      @(posedge clk) cap_go <= 1'b1;
      @(posedge clk) cap_go <= 1'b0;
      idle(3);
      @(negedge clk) chk(capw, 1'b1);
      chk(lsv, ev(1'b1, 1'b1));
      rd(`CILR_A_EXPCTL, 32'h100);
      rd(`CILR_A_LSV, ev(1'b1, 1'b1));
      @(posedge clk) cap_stop <= 1'b1;
      @(posedge clk) cap_stop <= 1'b0;
      idle(3);
      @(negedge clk) chk(capw, 1'b0);
      chk(out4, 1'b1);
      rd(`CILR_A_LSV, ev(1'b0, 1'b1));
      wr(`CILR_A_EXP_R, 20);
      wr(`CILR_A_EXP_G, 50);
      wr(`CILR_A_EXP_B, 10);
      // common scheme runs every channel on the red word
      expo(1, 20 + `CILR_EXP_OFS_CYC);
      wr(`CILR_A_EXPCTL, 32'h1);
      expo(1, 50 + `CILR_EXP_OFS_CYC);
      wr(`CILR_A_EXPCTL, 32'h11);
      expo(31, 20 + `CILR_EXP_OFS_CYC);
      wr(`CILR_A_EXPCTL, 32'h31);
      expo(41, 10 + `CILR_EXP_OFS_CYC);
      wr(`CILR_A_PU, 10);
      wr(`CILR_A_PU + 8'h4, 2);
      wr(`CILR_A_PU + 8'h8, 6);
      wr(`CILR_A_ROUTE1, 4);
      idle(20);
      n = 0;
      repeat (20) begin
         @(negedge clk);
         if (out1 === 1'b1) n++;
      end
      chk(n, 8);
      wr(`CILR_A_PU + 8'h1C, 32'h103);
      rd(`CILR_A_PU + 8'h1C, 32'h103);
      wr(`CILR_A_PU + 8'h1C, 32'h4);
      rd(`CILR_A_PU + 8'h1C, 32'h103);
      idle(4);
      end_of_test();
   end
endmodule : camera_io_line_router_tb
`default_nettype wire
